// ===== rtl/temp_zone_pkg.sv
// Constants and carrier types for the zone 3 / zone 4 source-select block.
// Assumes a byte-wide register port driven by the host's serial bus slave.
package temp_zone_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0] ZONE3_EXT_LOW_ADDR     = 8'h20;
	localparam logic [7:0] ZONE3_EXT_HIGH_ADDR    = 8'h21;
	localparam logic [7:0] ZONE4_EXT_LOW_ADDR     = 8'h22;
	localparam logic [7:0] ZONE4_EXT_HIGH_ADDR    = 8'h23;
	localparam logic [7:0] TEMP_SOURCE_SELECT_ADDR = 8'h31;
	localparam logic [7:0] ZONE3_PRIMARY_ADDR     = 8'h52;
	localparam logic [7:0] ZONE4_PRIMARY_ADDR     = 8'h53;
	localparam logic [7:0] UNMAPPED_READ_VALUE    = 8'h00;

	// ************************************************************
	// Field layout and reset values
	// ************************************************************
	localparam int         HALF_BIT_POS     = 7;
	localparam logic [7:0] ADC_OFFSET_FLIP  = 8'h80;
	localparam logic [7:0] ZONE_RESET_HIGH  = 8'h00;
	localparam logic       ZONE_RESET_HALF  = 1'b0;
	localparam logic [2:0] FINE_FRAC_PAD    = 3'h0;

	// Source-select byte, bit 0 in the lowest position
	typedef struct packed {
		logic int_write_enable;         // bit 4
		logic remote2b_pin_enable;      // bit 3
		logic remote1b_pin_enable;      // bit 2
		logic external_from_adc_select; // bit 1
		logic internal_from_adc_select; // bit 0
	} source_select_t;

	localparam source_select_t SELECT_RESET = 5'h00;
	localparam int             SELECT_WIDTH = 5;

	// Stored zone value: signed integer byte plus the half-degree bit
	typedef struct packed {
		logic [7:0] high;
		logic       half;
	} zone_value_t;

	// Value handed to consumers: integer byte and four fractional bits
	typedef struct packed {
		logic [7:0] integer_part;
		logic [3:0] fraction;
	} zone_fine_t;

	localparam zone_value_t ZONE_RESET = {ZONE_RESET_HIGH, ZONE_RESET_HALF};

endpackage

// ===== rtl/temp_zone_source_select.sv
// Zone 3 (internal) and zone 4 (external digital) extended temperature values
// and the source-select control byte, behind a byte-wide register port.
// Assumes the host's serial bus slave turns transfers into one-cycle
// read and write strobes, and that ADC and diode strobes are synchronous.
//
// Notes on behaviour
// - A zone is a sign-and-64..1 high byte plus a low byte of 0.5 in bit 7 and zeros below.
// - The zone 3 high byte always reads the same as the primary internal-zone value at 52h.
// - The zone 4 high byte always reads the same as the primary external-zone value at 53h.
// - With the internal ADC select set, zone 3 loads from channel eleven, MSB inverted.
// - With the internal ADC select clear, zone 3 loads from the on-die diode reading.
// - Consumers of zone 3 see the source the internal ADC select chooses, or host writes while the internal host-write enable is set.
// - External ADC select set: zone 4 is read-only and loads channel fifteen, MSB inverted.
// - External ADC select clear: zone 4 takes host writes and the block never updates it.
// - Consumers of zone 4 follow the source chosen by the external ADC select.
// - Remote-1b enable: shared pin is a second zone 1 diode input, else analog input one.
// - Remote-2b enable: shared pin is a second zone 2 diode input, else analog input two.
// - Internal host-write enable lets the host write zone 3 and stops its automatic updates.
// - The select byte holds the five controls in bits 0 to 4 and reserved zero bits above.
// - Fine values to consumers carry weights 0.5 to 0.0625 in the four fraction bits.
`timescale 1ns/1ns
module temp_zone_source_select
	import temp_zone_pkg::*;
(
	input  wire logic           core_clk,
	input  wire logic           sys_rst,
	input  wire logic [7:0]     reg_addr,
	input  wire logic [7:0]     reg_wdata,
	input  wire logic           reg_wr,
	input  wire logic           reg_rd,
	output logic [7:0]          reg_rdata,
	output logic                reg_rvalid,
	input  wire logic [7:0]     adc_channel_eleven,
	input  wire logic [7:0]     adc_channel_fifteen,
	input  wire logic           adc_update,
	input  wire logic [7:0]     diode_temp_high,
	input  wire logic           diode_temp_half,
	input  wire logic           diode_update,
	output zone_fine_t          zone3_fine,
	output zone_fine_t          zone4_fine,
	output logic                remote1b_pin_enable,
	output logic                remote2b_pin_enable
);

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [7:0] adc_to_signed(input logic [7:0] code);
		return code ^ ADC_OFFSET_FLIP;
	endfunction

	function automatic zone_fine_t to_fine(input zone_value_t v);
		return {v.high, v.half, FINE_FRAC_PAD};
	endfunction

	function automatic logic [7:0] low_byte(input zone_value_t v);
		logic [7:0] b;
		b = 8'h00;
		b[HALF_BIT_POS] = v.half;
		return b;
	endfunction

	// ************************************************************
	// Address decode
	// ************************************************************
	source_select_t select_r;
	zone_value_t    zone3_r;
	zone_value_t    zone4_r;

	logic hit_z3_low;
	logic hit_z3_high;
	logic hit_z4_low;
	logic hit_z4_high;
	logic hit_select;
	logic z3_host_ok;
	logic z4_host_ok;

	// The primary addresses alias the high bytes for writes as well as reads
	assign hit_z3_low  = reg_addr == ZONE3_EXT_LOW_ADDR;
	assign hit_z3_high = (reg_addr == ZONE3_EXT_HIGH_ADDR) || (reg_addr == ZONE3_PRIMARY_ADDR);
	assign hit_z4_low  = reg_addr == ZONE4_EXT_LOW_ADDR;
	assign hit_z4_high = (reg_addr == ZONE4_EXT_HIGH_ADDR) || (reg_addr == ZONE4_PRIMARY_ADDR);
	assign hit_select  = reg_addr == TEMP_SOURCE_SELECT_ADDR;
	assign z3_host_ok  = select_r.int_write_enable;
	assign z4_host_ok  = !select_r.external_from_adc_select;

	// ************************************************************
	// Source-select control
	// ************************************************************
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			select_r <= SELECT_RESET;
		end else if (reg_wr && hit_select) begin
			select_r <= reg_wdata[SELECT_WIDTH-1:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			remote1b_pin_enable <= 1'b0;
			remote2b_pin_enable <= 1'b0;
		end else begin
			remote1b_pin_enable <= select_r.remote1b_pin_enable;
			remote2b_pin_enable <= select_r.remote2b_pin_enable;
		end
	end

	// ************************************************************
	// Zone 3 value
	// ************************************************************
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			zone3_r <= ZONE_RESET;
		end else if (z3_host_ok) begin
			// Host mode shuts out both automatic sources, so a same-cycle ADC strobe loses
			if (reg_wr && hit_z3_high) begin
				zone3_r.high <= reg_wdata;
			end
			if (reg_wr && hit_z3_low) begin
				zone3_r.half <= reg_wdata[HALF_BIT_POS];
			end
		end else if (select_r.internal_from_adc_select) begin
			if (adc_update) begin
				zone3_r <= {adc_to_signed(adc_channel_eleven), 1'b0};
			end
		end else if (diode_update) begin
			zone3_r <= {diode_temp_high, diode_temp_half};
		end
	end

	// ************************************************************
	// Zone 4 value
	// ************************************************************
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			zone4_r <= ZONE_RESET;
		end else if (z4_host_ok) begin
			if (reg_wr && hit_z4_high) begin
				zone4_r.high <= reg_wdata;
			end
			if (reg_wr && hit_z4_low) begin
				zone4_r.half <= reg_wdata[HALF_BIT_POS];
			end
		end else if (adc_update) begin
			zone4_r <= {adc_to_signed(adc_channel_fifteen), 1'b0};
		end
	end

	// ************************************************************
	// Consumer outputs
	// ************************************************************
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			zone3_fine <= to_fine(ZONE_RESET);
			zone4_fine <= to_fine(ZONE_RESET);
		end else begin
			zone3_fine <= to_fine(zone3_r);
			zone4_fine <= to_fine(zone4_r);
		end
	end

	// ************************************************************
	// Register read
	// ************************************************************
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			reg_rdata  <= UNMAPPED_READ_VALUE;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				if (hit_z3_low) begin
					reg_rdata <= low_byte(zone3_r);
				end else if (hit_z3_high) begin
					reg_rdata <= zone3_r.high;
				end else if (hit_z4_low) begin
					reg_rdata <= low_byte(zone4_r);
				end else if (hit_z4_high) begin
					reg_rdata <= zone4_r.high;
				end else if (hit_select) begin
					reg_rdata <= {{(8-SELECT_WIDTH){1'b0}}, select_r};
				end else begin
					reg_rdata <= UNMAPPED_READ_VALUE;
				end
			end
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	chk_low_byte_zero: assert property (
		reg_rd && (hit_z3_low || hit_z4_low) |=> reg_rvalid && (reg_rdata[6:0] == 7'h00))
		else $error("low byte fraction bits not zero");

	chk_zone3_mirror: assert property (
		reg_rd && hit_z3_high |=> reg_rdata == $past(zone3_r.high))
		else $error("zone 3 high byte mirror mismatch");

	chk_zone4_mirror: assert property (
		reg_rd && hit_z4_high |=> reg_rdata == $past(zone4_r.high))
		else $error("zone 4 high byte mirror mismatch");

	chk_zone3_adc_load: assert property (
		!select_r.int_write_enable && select_r.internal_from_adc_select && adc_update
		|=> zone3_r.high == ($past(adc_channel_eleven) ^ ADC_OFFSET_FLIP) && !zone3_r.half
		##1 zone3_fine.integer_part == $past(zone3_r.high))
		else $error("zone 3 not loaded from channel eleven");

	chk_zone3_diode_load: assert property (
		!select_r.int_write_enable && !select_r.internal_from_adc_select && diode_update
		|=> zone3_r == {$past(diode_temp_high), $past(diode_temp_half)})
		else $error("zone 3 not loaded from diode");

	chk_zone4_readonly: assert property (
		select_r.external_from_adc_select && !adc_update && !(reg_wr && hit_select)
		|=> $stable(zone4_r))
		else $error("zone 4 changed while read-only");

	chk_zone4_host_only: assert property (
		!select_r.external_from_adc_select && !(reg_wr && (hit_z4_low || hit_z4_high))
		|=> $stable(zone4_r))
		else $error("zone 4 updated by block in host mode");

	chk_zone3_host_hold: assert property (
		select_r.int_write_enable && !(reg_wr && (hit_z3_low || hit_z3_high))
		|=> $stable(zone3_r))
		else $error("zone 3 auto update while host write enabled");

	chk_host_beats_adc: assert property (
		select_r.int_write_enable && reg_wr && hit_z3_high && adc_update
		|=> zone3_r.high == $past(reg_wdata))
		else $error("adc overwrote host write of zone 3");

	chk_select_layout: assert property (
		reg_wr && hit_select ##1 !(reg_wr && hit_select)
		|-> select_r == $past(reg_wdata[SELECT_WIDTH-1:0])
		##1 remote1b_pin_enable == select_r.remote1b_pin_enable
		&& remote2b_pin_enable == select_r.remote2b_pin_enable)
		else $error("select byte fields misplaced");

	chk_fine_format: assert property (
		##1 zone4_fine.fraction[2:0] == FINE_FRAC_PAD
		&& zone4_fine == to_fine($past(zone4_r)))
		else $error("zone 4 fine value wrong");

	// ************************************************************
	// Checks on sources, read-back and consumers
	// ************************************************************
	chk_zone4_adc_load: assert property (
		select_r.external_from_adc_select && adc_update
		|=> zone4_r.high == ($past(adc_channel_fifteen) ^ ADC_OFFSET_FLIP) && !zone4_r.half)
		else $error("zone 4 not loaded from channel fifteen");

	chk_zone4_alias_write: assert property (
		!select_r.external_from_adc_select && reg_wr && (reg_addr == ZONE4_PRIMARY_ADDR)
		|=> zone4_r.high == $past(reg_wdata))
		else $error("zone 4 alias write lost");

	chk_zone3_adc_only: assert property (
		!select_r.int_write_enable && select_r.internal_from_adc_select && !adc_update
		|=> $stable(zone3_r))
		else $error("zone 3 changed without an ADC strobe");

	chk_zone3_diode_only: assert property (
		!select_r.int_write_enable && !select_r.internal_from_adc_select && !diode_update
		|=> $stable(zone3_r))
		else $error("zone 3 changed without a diode strobe");

	chk_zone3_half_read: assert property (
		reg_rd && hit_z3_low |=> reg_rdata[HALF_BIT_POS] == $past(zone3_r.half))
		else $error("zone 3 half bit read wrong");

	chk_zone4_half_read: assert property (
		reg_rd && hit_z4_low |=> reg_rdata[HALF_BIT_POS] == $past(zone4_r.half))
		else $error("zone 4 half bit read wrong");

	chk_select_readback: assert property (
		reg_rd && hit_select
		|=> reg_rdata[SELECT_WIDTH-1:0] == $past(select_r) && (reg_rdata >> SELECT_WIDTH) == 8'h00)
		else $error("select byte read-back wrong");

	chk_pin1_follow: assert property (
		##1 remote1b_pin_enable == $past(select_r.remote1b_pin_enable))
		else $error("remote-1b pin enable not following select");

	chk_pin2_follow: assert property (
		##1 remote2b_pin_enable == $past(select_r.remote2b_pin_enable))
		else $error("remote-2b pin enable not following select");

	chk_zone3_fine_follow: assert property (
		##1 zone3_fine.integer_part == $past(zone3_r.high)
		&& zone3_fine.fraction[3] == $past(zone3_r.half))
		else $error("zone 3 consumer value stale");

	chk_zone4_fine_follow: assert property (
		##1 zone4_fine.integer_part == $past(zone4_r.high)
		&& zone4_fine.fraction[3] == $past(zone4_r.half))
		else $error("zone 4 consumer value stale");

endmodule

// ===== tb/host_model.sv
// Host stand-in for the serial bus slave: one-cycle register strobes.
// Assumes reg_rvalid answers a read one cycle after the strobe.
`timescale 1ns/1ns
module host_model (
	input  wire logic       core_clk,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// Host refreshes values itself; released lines show inverted data
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
		reg_addr  <= ~a;
		reg_wdata <= ~d;
	endtask
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
		ok = 1'b0;
		d = 8'h00;
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd   <= 1'b0;
		reg_addr <= ~a;
		for (int i = 0; i < 3 && !ok; i++) begin
			#1;
			if (reg_rvalid === 1'b1) begin
				ok = 1'b1;
				d = reg_rdata;
			end else
				@(posedge core_clk);
		end
	endtask
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the zone 3 / zone 4 source-select block.
// Assumes host_model drives the register port.
`timescale 1ns/1ns
module testbench;
	import temp_zone_pkg::*;
	logic       core_clk, sys_rst, reg_wr, reg_rd, reg_rvalid, adc_update, diode_update;
	logic       diode_temp_half, remote1b_pin_enable, remote2b_pin_enable;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, adc_channel_eleven, adc_channel_fifteen;
	logic [7:0] diode_temp_high;
	zone_fine_t zone3_fine, zone4_fine;
	int         mismatches, checks;
	always #10 core_clk = ~core_clk;
	host_model host (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
	temp_zone_source_select DUT (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .adc_channel_eleven(adc_channel_eleven),
		.adc_channel_fifteen(adc_channel_fifteen), .adc_update(adc_update),
		.diode_temp_high(diode_temp_high), .diode_temp_half(diode_temp_half),
		.diode_update(diode_update), .zone3_fine(zone3_fine), .zone4_fine(zone4_fine),
		.remote1b_pin_enable(remote1b_pin_enable), .remote2b_pin_enable(remote2b_pin_enable));
	// ************************************************************
	// Helpers
	// ************************************************************
	task automatic finish_test;
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic       ok;
		host.read_reg(a, d, ok);
		if (!ok) begin
			mismatches++;
			$display("MISMATCH t=%0t rvalid=%h exp=%h", $time, 1'b0, 1'b1);
			finish_test();
		end else begin
			cmp({4'h0, d}, {4'h0, exp});
		end
	endtask
	task automatic pulse(input logic [7:0] a11, input logic [7:0] a15, input logic [7:0] dh,
		input logic dhalf, input logic adc, input logic dio);
		@(posedge core_clk);
		adc_channel_eleven  <= a11;
		adc_channel_fifteen <= a15;
		diode_temp_high     <= dh;
		diode_temp_half     <= dhalf;
		adc_update          <= adc;
		diode_update        <= dio;
		@(posedge core_clk);
		adc_update   <= 1'b0;
		diode_update <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
	endtask
	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reset;
		logic [7:0] addrs [8] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h31, 8'h52, 8'h53, 8'h40};
		foreach (addrs[i])
			rd_chk(addrs[i], 8'h00);
		cmp({remote1b_pin_enable, remote2b_pin_enable, zone3_fine[9:0]}, 12'h000);
		cmp(zone4_fine, 12'h000);
	endtask
	task automatic t_select;
		host.write_reg(8'h31, 8'hff);
		rd_chk(8'h31, 8'h1f);
		cmp({10'h000, remote1b_pin_enable, remote2b_pin_enable}, 12'h003);
		host.write_reg(8'h31, 8'h04);
		rd_chk(8'h31, 8'h04);
		cmp({10'h000, remote1b_pin_enable, remote2b_pin_enable}, 12'h002);
	endtask
	task automatic t_diode;
		host.write_reg(8'h31, 8'h00);
		pulse(8'h90, 8'h00, 8'h25, 1'b1, 1'b1, 1'b1);
		cmp(zone3_fine, 12'h258);
		rd_chk(8'h21, 8'h25);
		rd_chk(8'h20, 8'h80);
		rd_chk(8'h52, 8'h25);
	endtask
	task automatic t_adc_zone3;
		host.write_reg(8'h31, 8'h01);
		pulse(8'h90, 8'h05, 8'h33, 1'b0, 1'b1, 1'b1);
		cmp(zone3_fine, 12'h100);
		cmp(zone4_fine, 12'h000);
		rd_chk(8'h21, 8'h10);
		rd_chk(8'h20, 8'h00);
		host.write_reg(8'h21, 8'h55);
		rd_chk(8'h21, 8'h10);
	endtask
	task automatic t_host_zone4;
		host.write_reg(8'h23, 8'he7);
		host.write_reg(8'h22, 8'hff);
		rd_chk(8'h23, 8'he7);
		rd_chk(8'h22, 8'h80);
		rd_chk(8'h53, 8'he7);
		cmp(zone4_fine, 12'he78);
	endtask
	task automatic t_adc_zone4;
		host.write_reg(8'h31, 8'h03);
		pulse(8'h00, 8'h05, 8'h00, 1'b0, 1'b1, 1'b0);
		cmp(zone4_fine, 12'h850);
		rd_chk(8'h22, 8'h00);
		host.write_reg(8'h23, 8'h11);
		rd_chk(8'h23, 8'h85);
	endtask
	task automatic t_host_zone3;
		host.write_reg(8'h31, 8'h11);
		host.write_reg(8'h21, 8'h3c);
		host.write_reg(8'h20, 8'hff);
		pulse(8'h90, 8'h00, 8'h44, 1'b0, 1'b1, 1'b1);
		rd_chk(8'h21, 8'h3c);
		rd_chk(8'h20, 8'h80);
		cmp(zone3_fine, 12'h3c8);
		// Host write through the alias and an ADC strobe on the same edge
		fork
			host.write_reg(8'h52, 8'h5a);
			pulse(8'h90, 8'h00, 8'h44, 1'b0, 1'b1, 1'b1);
		join
		rd_chk(8'h21, 8'h5a);
	endtask
	initial begin
		core_clk = 1'b0;
		sys_rst = 1'b1;
		adc_update = 1'b0;
		diode_update = 1'b0;
		adc_channel_eleven = 8'h00;
		adc_channel_fifteen = 8'h00;
		diode_temp_high = 8'h00;
		diode_temp_half = 1'b0;
		mismatches = 0;
		checks = 0;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		t_reset();
		t_select();
		t_diode();
		t_adc_zone3();
		t_host_zone4();
		t_adc_zone4();
		t_host_zone3();
		finish_test();
	end
endmodule
